//--- src/dcc_cfg.svh
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
// Overview of operation
// - Peak-current ceiling field, code n means 6 mA times (n+1), 6 to 96 mA.
// - Peak-current floor field, same 6 mA steps, reset code gives 30 mA.
// - Output-good flag clears after 2, 4, 8 or 15 consecutive not-OK events.
// - Switch held active past 0.25 us multiples forces next state; code 0 off.
// - Idle output monitoring paced by clock divided by 4, 8, 16 or 32.
// - Enable bit zero keeps converter off; one hands it to hardware control.

// Register byte addresses
`define DCC_CTRL_ADDR   32'h5000_0080
`define DCC_STAT_ADDR   32'h5000_0084
`define DCC_ISTS_ADDR   32'h5000_0088
`define DCC_IMSK_ADDR   32'h5000_008C

// Control register layout and reset value
`define DCC_CTRL_RST    16'h84A2
`define DCC_CEIL_LSB    12
`define DCC_FLOOR_LSB   8
`define DCC_CLRCNT_LSB  6
`define DCC_TO_LSB      3
`define DCC_DIV_LSB     1
`define DCC_EN_BIT      0

// Status register layout
`define DCC_ST_GOOD_BIT 0
`define DCC_ST_STATE_LSB 1
`define DCC_ST_ILIM_LSB 4

// Interrupt status and mask bits
`define DCC_IRQ_W       3
`define DCC_IRQ_GOOD_UP 0
`define DCC_IRQ_GOOD_DN 1
`define DCC_IRQ_TIMEOUT 2

// Not-OK run lengths per code
`define DCC_CLR_CNT0    4'h2
`define DCC_CLR_CNT1    4'h4
`define DCC_CLR_CNT2    4'h8
`define DCC_CLR_CNT3    4'hF

// Timing
`define DCC_CLK_NS      4
`define DCC_TO_STEP_NS  250
`define DCC_DIV_MIN     9'h004
`define DCC_TMR_W       9

// Bus answers
`define DCC_RESP_OKAY   2'h0
`define DCC_RESP_SLVERR 2'h2

`endif

//--- src/dcc_pkg.sv
package dcc_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_IDLE,
        ST_CHARGE,
        ST_DISCHARGE
    } dcc_state_t;

    typedef struct packed {
        logic [8:0] cnt;
    } dcc_tmr_t;

    typedef struct packed {
        // Bus side
        logic        awready;
        logic        wready;
        logic        aw_full;
        logic [31:0] aw_addr;
        logic        w_full;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        // Registers
        logic [15:0] ctrl;
        logic [2:0]  ists;
        logic [2:0]  imsk;
        logic        irq;
        // Comparator synchronisers
        logic        nok_s1;
        logic        nok_s2;
        logic        pk_s1;
        logic        pk_s2;
        logic        zc_s1;
        logic        zc_s2;
        // Converter
        dcc_state_t  st;
        logic [3:0]  nok_cnt;
        logic        good;
        logic [3:0]  ilim;
        logic        conv_en;
        logic        sw_chg;
        logic        sw_dis;
    } dcc_regs_t;

endpackage : dcc_pkg

//--- src/dcc_timer.sv
`timescale 1ns/1ns
`include "dcc_cfg.svh"

module dcc_timer (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Control
    input  wire logic                  load,
    input  wire logic [`DCC_TMR_W-1:0] load_val,
    // Status
    output logic                       done
);

    dcc_pkg::dcc_tmr_t r;
    dcc_pkg::dcc_tmr_t n;

    always_comb begin
        n = r;
        if (load) begin
            n.cnt = load_val;
        end else if (r.cnt != '0) begin
            n.cnt = r.cnt - 9'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Done reads only the count: gating it by load would close a
    // combinational loop through the caller, which decides load from done
    assign done = (r.cnt == '0);

endmodule : dcc_timer

//--- src/dcc_ctrl.sv
`timescale 1ns/1ns
`include "dcc_cfg.svh"

module dcc_ctrl (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Comparators from the power stage, asynchronous
    input  wire logic        out_not_ok,
    input  wire logic        peak_reached,
    input  wire logic        zero_cross,
    // Power stage drive
    output logic             conv_enable,
    output logic             switch_charge,
    output logic             switch_discharge,
    output logic [3:0]       peak_current_limit,
    output logic             output_good_flag,
    // Interrupt
    output logic             irq
);

    dcc_pkg::dcc_regs_t r;
    dcc_pkg::dcc_regs_t n;

    logic                  idle_load;
    logic [`DCC_TMR_W-1:0] idle_val;
    logic                  idle_done;
    logic                  to_load;
    logic [`DCC_TMR_W-1:0] to_val;
    logic                  to_done;

    // Ceiling wins if software sets the floor above it
    function automatic logic [3:0] lim_clamp(
        input logic [3:0] x,
        input logic [3:0] lo,
        input logic [3:0] hi
    );
        logic [3:0] y;
        y = x;
        if (y < lo) begin
            y = lo;
        end
        if (y > hi) begin
            y = hi;
        end
        return y;
    endfunction : lim_clamp

    function automatic logic [3:0] clr_thr(input logic [1:0] code);
        logic [3:0] t;
        t = `DCC_CLR_CNT2;
        case (code)
            2'h0: t = `DCC_CLR_CNT0;
            2'h1: t = `DCC_CLR_CNT1;
            2'h2: t = `DCC_CLR_CNT2;
            default: t = `DCC_CLR_CNT3;
        endcase
        return t;
    endfunction : clr_thr

    // Longest time, so the division rounds down
    function automatic logic [`DCC_TMR_W-1:0] to_cycles(
        input logic [2:0] code
    );
        int unsigned c;
        c = (32'(code) * `DCC_TO_STEP_NS) / `DCC_CLK_NS;
        return c[`DCC_TMR_W-1:0];
    endfunction : to_cycles

    // Tick period minus one, since the timer also spends the reload cycle
    function automatic logic [`DCC_TMR_W-1:0] div_reload(
        input logic [1:0] code
    );
        logic [`DCC_TMR_W-1:0] d;
        d = `DCC_DIV_MIN << code;
        return d - 9'h001;
    endfunction : div_reload

    function automatic logic sel(
        input logic [31:0] addr,
        input logic [31:0] base
    );
        return addr[31:2] == base[31:2];
    endfunction : sel

    always_comb begin
        logic [`DCC_IRQ_W-1:0] ev;
        logic [`DCC_IRQ_W-1:0] clr;
        logic [3:0]            ceil_c;
        logic [3:0]            floor_c;
        logic                  to_on;
        logic                  to_hit;
        logic [15:0]           wmask;
        ev        = '0;
        clr       = '0;
        idle_load = 1'b0;
        idle_val  = div_reload(r.ctrl[`DCC_DIV_LSB +: 2]);
        to_load   = 1'b0;
        to_val    = to_cycles(r.ctrl[`DCC_TO_LSB +: 3]);
        n         = r;
        ceil_c    = r.ctrl[`DCC_CEIL_LSB +: 4];
        floor_c   = r.ctrl[`DCC_FLOOR_LSB +: 4];
        to_on     = r.ctrl[`DCC_TO_LSB +: 3] != 3'h0;
        to_hit    = to_on && to_done;
        wmask     = {{8{r.wstrb[1]}}, {8{r.wstrb[0]}}};

        // Comparator inputs pass two flip-flops
        n.nok_s1 = out_not_ok;
        n.nok_s2 = r.nok_s1;
        n.pk_s1  = peak_reached;
        n.pk_s2  = r.pk_s1;
        n.zc_s1  = zero_cross;
        n.zc_s2  = r.zc_s1;

        // Write channel: address and data taken in either order
        if (awvalid && r.awready) begin
            n.aw_full = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && r.wready) begin
            n.w_full = 1'b1;
            n.wdata  = wdata;
            n.wstrb  = wstrb;
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_full && r.w_full && !r.bvalid) begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `DCC_RESP_OKAY;
            if (sel(r.aw_addr, `DCC_CTRL_ADDR)) begin
                n.ctrl = (r.ctrl & ~wmask) | (r.wdata[15:0] & wmask);
            end else if (sel(r.aw_addr, `DCC_ISTS_ADDR)) begin
                if (r.wstrb[0]) begin
                    clr = r.wdata[`DCC_IRQ_W-1:0];
                end
            end else if (sel(r.aw_addr, `DCC_IMSK_ADDR)) begin
                if (r.wstrb[0]) begin
                    n.imsk = r.wdata[`DCC_IRQ_W-1:0];
                end
            end else if (!sel(r.aw_addr, `DCC_STAT_ADDR)) begin
                n.bresp = `DCC_RESP_SLVERR;
            end
        end
        n.awready = !n.aw_full && !n.bvalid;
        n.wready  = !n.w_full && !n.bvalid;

        // Read channel
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = `DCC_RESP_OKAY;
            n.rdata  = '0;
            if (sel(araddr, `DCC_CTRL_ADDR)) begin
                n.rdata[15:0] = r.ctrl;
            end else if (sel(araddr, `DCC_STAT_ADDR)) begin
                n.rdata[`DCC_ST_GOOD_BIT]      = r.good;
                n.rdata[`DCC_ST_STATE_LSB +: 3] = r.st;
                n.rdata[`DCC_ST_ILIM_LSB +: 4] = r.ilim;
            end else if (sel(araddr, `DCC_ISTS_ADDR)) begin
                n.rdata[`DCC_IRQ_W-1:0] = r.ists;
            end else if (sel(araddr, `DCC_IMSK_ADDR)) begin
                n.rdata[`DCC_IRQ_W-1:0] = r.imsk;
            end else begin
                n.rresp = `DCC_RESP_SLVERR;
            end
        end
        n.arready = !n.rvalid;

        // Converter sequencing
        n.ilim = lim_clamp(r.ilim, floor_c, ceil_c);
        if (!r.ctrl[`DCC_EN_BIT]) begin
            n.st      = dcc_pkg::ST_OFF;
            n.conv_en = 1'b0;
            n.sw_chg  = 1'b0;
            n.sw_dis  = 1'b0;
            n.nok_cnt = '0;
            n.good    = 1'b0;
        end else begin
            n.conv_en = 1'b1;
            case (r.st)
                dcc_pkg::ST_OFF: begin
                    n.st      = dcc_pkg::ST_IDLE;
                    idle_load = 1'b1;
                end
                dcc_pkg::ST_IDLE: begin
                    if (!idle_done) begin
                        n.st = dcc_pkg::ST_IDLE;
                    end else if (r.nok_s2) begin
                        // Run of not-OK samples, saturating
                        if (r.nok_cnt != 4'hF) begin
                            n.nok_cnt = r.nok_cnt + 4'h1;
                        end
                        if (n.nok_cnt >= clr_thr(
                                r.ctrl[`DCC_CLRCNT_LSB +: 2])) begin
                            n.good = 1'b0;
                        end
                        n.st     = dcc_pkg::ST_CHARGE;
                        n.sw_chg = 1'b1;
                        to_load  = 1'b1;
                    end else begin
                        n.nok_cnt = '0;
                        n.good    = 1'b1;
                        idle_load = 1'b1;
                    end
                end
                dcc_pkg::ST_CHARGE: begin
                    if (r.pk_s2 || to_hit) begin
                        n.st     = dcc_pkg::ST_DISCHARGE;
                        n.sw_chg = 1'b0;
                        n.sw_dis = 1'b1;
                        to_load  = 1'b1;
                        if (to_hit && !r.pk_s2) begin
                            // Peak not reached: limit too high
                            n.ilim = lim_clamp(r.ilim - 4'h1,
                                floor_c, ceil_c);
                            if (r.ilim == 4'h0) begin
                                n.ilim = floor_c;
                            end
                            ev[`DCC_IRQ_TIMEOUT] = 1'b1;
                        end else if (r.nok_cnt > 4'h1) begin
                            // Output still weak: allow more current
                            n.ilim = lim_clamp(r.ilim + 4'h1,
                                floor_c, ceil_c);
                            if (r.ilim == 4'hF) begin
                                n.ilim = ceil_c;
                            end
                        end
                    end
                end
                dcc_pkg::ST_DISCHARGE: begin
                    if (r.zc_s2 || to_hit) begin
                        n.st      = dcc_pkg::ST_IDLE;
                        n.sw_dis  = 1'b0;
                        idle_load = 1'b1;
                        if (to_hit && !r.zc_s2) begin
                            ev[`DCC_IRQ_TIMEOUT] = 1'b1;
                        end
                    end
                end
                default: begin
                    n.st     = dcc_pkg::ST_OFF;
                    n.sw_chg = 1'b0;
                    n.sw_dis = 1'b0;
                end
            endcase
        end

        // Output-good edges
        ev[`DCC_IRQ_GOOD_UP] = n.good && !r.good;
        ev[`DCC_IRQ_GOOD_DN] = !n.good && r.good;

        // A new event beats a clear in the same cycle
        n.ists = (r.ists & ~clr) | ev;
        n.irq  = |(n.ists & n.imsk);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r         <= '0;
            r.st      <= dcc_pkg::ST_OFF;
            r.ctrl    <= `DCC_CTRL_RST;
            r.ilim    <= 4'(`DCC_CTRL_RST >> `DCC_FLOOR_LSB);
            r.bresp   <= `DCC_RESP_OKAY;
            r.rresp   <= `DCC_RESP_OKAY;
        end else begin
            r <= n;
        end
    end

    dcc_timer u_idle_tmr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (idle_load),
        .load_val (idle_val),
        .done     (idle_done)
    );

    dcc_timer u_to_tmr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (to_load),
        .load_val (to_val),
        .done     (to_done)
    );

    assign awready            = r.awready;
    assign wready             = r.wready;
    assign bvalid             = r.bvalid;
    assign bresp              = r.bresp;
    assign arready            = r.arready;
    assign rvalid             = r.rvalid;
    assign rdata              = r.rdata;
    assign rresp              = r.rresp;
    assign conv_enable        = r.conv_en;
    assign switch_charge      = r.sw_chg;
    assign switch_discharge   = r.sw_dis;
    assign peak_current_limit = r.ilim;
    assign output_good_flag   = r.good;
    assign irq                = r.irq;

endmodule : dcc_ctrl

//--- test/dcc_stage_model.sv
`timescale 1ns/1ns

module dcc_stage_model (
    // Clock
    input  wire logic aclk,
    // Bench controls
    input  wire logic heavy,
    input  wire logic slow,
    // Switch drive
    input  wire logic switch_charge,
    input  wire logic switch_discharge,
    // Comparators
    output logic      out_not_ok,
    output logic      peak_reached,
    output logic      zero_cross
);
    int up;
    int dn;

    // Current ramps for a few cycles, so the sync latency is really seen
    always @(posedge aclk) begin
        up <= switch_charge ? up + 1 : 0;
        dn <= switch_discharge ? dn + 1 : 0;
    end

    // A slow stage never reaches the peak, leaving only the switch timeout
    assign out_not_ok   = heavy;
    assign peak_reached = switch_charge && !slow && up >= 3;
    assign zero_cross   = switch_discharge && dn >= 2;
endmodule : dcc_stage_model

//--- test/dcc_ctrl_asserts.sv
`timescale 1ns/1ns

module dcc_ctrl_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // Power stage
    input wire logic out_not_ok,
    input wire logic conv_enable,
    input wire logic switch_charge,
    input wire logic switch_discharge,
    input wire logic output_good_flag
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_off_quiet: assert property (
        !conv_enable |-> !switch_charge && !switch_discharge)
        else $error("switch on while disabled");
    chk_one_switch: assert property (
        !(switch_charge && switch_discharge))
        else $error("both switches on");
    chk_charge_to_dis: assert property (
        $fell(switch_charge) && conv_enable |-> switch_discharge)
        else $error("charge not followed by discharge");
    chk_good_cause: assert property (
        $fell(output_good_flag) |->
            !conv_enable || $past(out_not_ok, 3) || $past(out_not_ok, 4))
        else $error("good flag cleared without not-ok run");
    chk_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_ar_block: assert property (rvalid |-> !arready)
        else $error("read address taken during answer");
    chk_b_answer: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write answer late");
    chk_b_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken during answer");
endmodule : dcc_ctrl_asserts

bind dcc_ctrl dcc_ctrl_asserts u_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .out_not_ok(out_not_ok),
    .conv_enable(conv_enable), .switch_charge(switch_charge),
    .switch_discharge(switch_discharge),
    .output_good_flag(output_good_flag)
);

//--- test/test_dcc_ctrl.sv
`timescale 1ns/1ns
`include "dcc_cfg.svh"

module test_dcc_ctrl;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  ilim;
    logic [2:0]  prot;
    logic [1:0]  bresp, rresp, rsp;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic        nok, pk, zc, en, sc, sd, good, irq, heavy, slow, sc_q;
    int          mismatches, check_count, seed, cyc, rises, n, t0, i, v;
    int          exp_lim;

    dcc_ctrl u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(prot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .out_not_ok(nok), .peak_reached(pk), .zero_cross(zc),
        .conv_enable(en), .switch_charge(sc), .switch_discharge(sd),
        .peak_current_limit(ilim), .output_good_flag(good), .irq(irq)
    );

    dcc_stage_model u_stage (
        .aclk(aclk), .heavy(heavy), .slow(slow), .switch_charge(sc),
        .switch_discharge(sd), .out_not_ok(nok), .peak_reached(pk),
        .zero_cross(zc)
    );

    always #2 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        sc_q <= sc;
        if (sc && !sc_q) rises <= rises + 1;
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= d;
        prot <= 3'($random(seed));
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            k++;
        end while (bvalid !== 1'b1 && k < 200);
        if (bvalid !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: write not answered", $time);
        end
        rsp = bresp;
    endtask : wr

    task automatic rdr(input logic [31:0] a);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            k++;
        end while (rvalid !== 1'b1 && k < 200);
        if (rvalid !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: read not answered", $time);
        end
        rd = rdata;
        rsp = rresp;
    endtask : rdr

    // Stop the converter first so every run starts from a fresh idle
    task automatic cfg(input logic [31:0] d);
        wr(`DCC_CTRL_ADDR, 32'h8400);
        repeat (2) @(posedge aclk);
        chk({en, sc, sd, good}, 32'h0);
        wr(`DCC_CTRL_ADDR, d);
    endtask : cfg

    task automatic wait_for(input int w, input logic want);
        int k;
        for (k = 0; k < 4000; k++) begin
            if ((w == 0 ? en : (w == 1 ? sc : good)) === want) break;
            @(posedge aclk);
        end
        if (k == 4000) begin
            mismatches++;
            $display("wrong value at %0t: output never changed", $time);
        end
    endtask : wait_for

    function automatic int clampl(input int x, input int c);
        if (x < ((c >> 8) & 15)) x = (c >> 8) & 15;
        if (x > ((c >> 12) & 15)) x = (c >> 12) & 15;
        return x;
    endfunction : clampl

    initial begin
        #200000;
        mismatches++;
        results();
    end

    initial begin
        {aclk, aresetn, awvalid, wvalid, arvalid, heavy, slow} = 7'h00;
        {awaddr, wdata, araddr, prot} = '0;
        {bready, rready} = 2'h3;
        seed = 32;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(`DCC_CTRL_ADDR);
        chk(rd, 32'h84A2);
        rdr(`DCC_STAT_ADDR);
        chk(rd, 32'h40);
        rdr(`DCC_IMSK_ADDR);
        chk(rd, 32'h0);
        rdr(32'h5000_0090);
        chk(rsp, `DCC_RESP_SLVERR);
        chk(rd, 32'h0);
        wr(32'h5000_0094, 32'hFFFF);
        chk(rsp, `DCC_RESP_SLVERR);
        exp_lim = 4;
        for (i = 0; i < 7; i++) begin
            v = i < 5 ? $random(seed) & 32'hFFFE
                      : (i == 5 ? 32'h2500 : 32'hF600);
            wr(`DCC_CTRL_ADDR, v);
            rdr(`DCC_CTRL_ADDR);
            chk(rd, v);
            exp_lim = clampl(exp_lim, v);
            rdr(`DCC_STAT_ADDR);
            chk(rd[7:4], exp_lim);
            chk(ilim, exp_lim);
        end
        $display("register test done");
        heavy <= 1'b1;
        for (i = 0; i < 4; i++) begin
            cfg(32'h84A1 | (i << 1));
            wait_for(0, 1'b1);
            t0 = cyc;
            wait_for(1, 1'b1);
            n = cyc - t0;
            chk(n >= (4 << i) - 1 && n <= (4 << i) + 3, 1);
        end
        $display("divider test done");
        for (i = 0; i < 4; i++) begin
            heavy <= 1'b0;
            cfg(32'h8421 | (i << 6));
            wait_for(2, 1'b1);
            heavy <= 1'b1;
            t0 = rises;
            wait_for(2, 1'b0);
            repeat (4) @(posedge aclk);
            chk(rises - t0, i == 3 ? 15 : 2 << i);
        end
        $display("good flag test done");
        slow <= 1'b1;
        for (i = 1; i < 8; i += 6) begin
            cfg(32'h8481 | (i << 3));
            wait_for(1, 1'b1);
            t0 = cyc;
            wait_for(1, 1'b0);
            n = cyc - t0;
            chk(n >= i * 250 / 4 && n <= i * 250 / 4 + 2, 1);
        end
        // Timeout events must sit in status but stay masked off the line
        chk(irq, 1'b0);
        rdr(`DCC_ISTS_ADDR);
        chk(rd[2], 1'b1);
        wr(`DCC_IMSK_ADDR, 32'h4);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1);
        heavy <= 1'b0;
        slow <= 1'b0;
        repeat (100) @(posedge aclk);
        wr(`DCC_ISTS_ADDR, 32'h4);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        rdr(`DCC_ISTS_ADDR);
        chk(rd[2], 1'b0);
        $display("timeout and interrupt test done");
        heavy <= 1'b1;
        slow <= 1'b1;
        cfg(32'h8481);
        wait_for(1, 1'b1);
        repeat (500) @(posedge aclk);
        chk(sc, 1'b1);
        slow <= 1'b0;
        repeat (30) @(posedge aclk);
        rdr(`DCC_STAT_ADDR);
        chk(rd[7:4] >= 4 && rd[7:4] <= 8, 1);
        cfg(32'h8400);
        $display("timeout off test done");
        results();
    end
endmodule : test_dcc_ctrl
